/* rtl/data_space_pkg.sv */
package data_space_pkg;

  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] PRI_IVT_LO = 24'h000004;
  localparam logic [23:0] PRI_IVT_HI = 24'h0000ff;
  localparam logic [23:0] ALT_IVT_LO = 24'h000100;
  localparam logic [23:0] ALT_IVT_HI = 24'h0001ff;
  localparam logic [23:0] VECTOR_END = 24'h000200;

  localparam int PSV_BIT = 15;
  localparam logic [15:0] SFR_LIMIT = 16'h0800;
  localparam logic [15:0] NEAR_MASK = 16'h1fff;
  localparam logic [15:0] RAM_LIMIT_DEF = 16'h8000;
  localparam logic [15:0] XY_BOUNDARY_DEF = 16'h4800;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int BITREV_BITS = 8;

  typedef enum logic [1:0] {PC_HOLD = 2'h0, PC_FWD = 2'h1, PC_LOAD = 2'h3, PC_BACK = 2'h2} pc_cmd_t;
  typedef enum logic [1:0] {ZONE_RESET = 2'h0, ZONE_PRI_IVT = 2'h1, ZONE_ALT_IVT = 2'h3, ZONE_USER = 2'h2} pc_zone_t;
  typedef enum logic [1:0] {EXT_NONE = 2'h0, EXT_SIGN = 2'h1, EXT_ZERO = 2'h2, EXT_LOAD_LOW = 2'h3} ext_op_t;
  typedef enum logic [1:0] {SRC_ZERO = 2'h0, SRC_RAM = 2'h1, SRC_SFR = 2'h2, SRC_PSV = 2'h3} src_t;

  typedef struct packed {
    logic valid;
    logic is_byte;
    logic near_field;
    logic post_inc;
    logic modulo_en;
    ext_op_t ext;
    logic [15:0] addr;
  } rd_req_t;

  typedef struct packed {
    logic valid;
    logic is_byte;
    logic near_field;
    logic bitrev;
    logic [15:0] addr;
    logic [15:0] data;
  } wr_req_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] end_addr;
  } mod_cfg_t;

  typedef struct packed {
    logic valid;
    logic hi_byte;
    logic is_byte;
    ext_op_t ext;
    src_t src;
  } rd_stage_t;

  typedef struct packed {
    logic ram_en;
    logic sfr_en;
    logic psv_en;
    logic [14:0] word_addr;
  } rd_port_t;

  typedef struct packed {
    logic en;
    logic [1:0] be;
    logic [14:0] word_addr;
    logic [15:0] data;
  } wr_port_t;

  typedef struct packed {
    logic [23:0] pc;
    pc_zone_t zone;
    logic [23:0] instr;
    rd_port_t x_port;
    rd_port_t y_port;
    wr_port_t wr;
    rd_stage_t x_stage;
    rd_stage_t y_stage;
    logic [15:0] x_data;
    logic x_valid;
    logic [15:0] y_data;
    logic y_valid;
    logic [15:0] x_next;
    logic [15:0] y_next;
    logic err;
    logic err_wr;
  } core_state_t;

endpackage

/* rtl/data_space_access_unit.sv */
`timescale 1ns/1ps
// Functional notes
// RQ1: Instruction word is lower word plus low byte of upper word; top byte ignored.
// RQ2: Program counter stays even and steps by two forward or back.
// RQ3: Vectors live below 0x000200; after reset execution begins at 0x000000.
// RQ4: Primary handler table 0x000004-0x0000ff, alternate table 0x000100-0x0001ff.
// RQ5: Data effective address is 16 bits selecting a byte.
// RQ6: Top address bit clear goes to data memory, set goes to program visibility window.
// RQ7: Up to 30 Kbytes of RAM; reads of unimplemented addresses return zero.
// RQ8: Low byte at even address, high byte at odd address.
// RQ9: Post-increment pointer moves by one for bytes, two for words.
// RQ10: Byte read fetches whole word and puts selected byte on low lane.
// RQ11: Shared word decode, separate byte strobes; byte write touches its lane only.
// RQ12: Word access at odd address raises address error trap.
// RQ13: Misaligned read completes; misaligned write is suppressed; trap follows either way.
// RQ14: Byte load into working register keeps its high byte.
// RQ15: Sign-extend and zero-extend operations on byte data.
// RQ16: 0x0000-0x07ff decodes to special function registers; unused ones read zero.
// RQ17: 13-bit direct field reaches 0x0000-0x1fff.
// RQ18: 16-bit direct field or pointer reaches the whole data space.
// RQ19: X and Y have separate generators and paths for dual reads.
// RQ20: X read bus serves unified reads and X prefetch of multiply-accumulate.
// RQ21: Y read only for multiply-accumulate; all writes use one combined path.
// RQ22: Modulo addressing on X and Y; bit-reversal on X writes only.
// RQ23: X/Y boundary is a fixed build parameter.
// RQ24: Address error is a one-cycle pulse with read/write indication.
module data_space_access_unit #(
  parameter logic [15:0] RAM_LIMIT = data_space_pkg::RAM_LIMIT_DEF,
  parameter logic [15:0] XY_BOUNDARY = data_space_pkg::XY_BOUNDARY_DEF
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire data_space_pkg::pc_cmd_t pc_cmd_in,
  input wire logic [23:0] pc_target_in,
  input wire logic [15:0] prog_lower_in,
  input wire logic [15:0] prog_upper_in,
  input wire data_space_pkg::rd_req_t x_rd_in,
  input wire data_space_pkg::rd_req_t y_rd_in,
  input wire data_space_pkg::wr_req_t wr_in,
  input wire data_space_pkg::mod_cfg_t x_mod_in,
  input wire data_space_pkg::mod_cfg_t y_mod_in,
  input wire logic [15:0] x_wreg_old_in,
  input wire logic [15:0] x_ram_rdata_in,
  input wire logic [15:0] y_ram_rdata_in,
  input wire logic [15:0] sfr_rdata_in,
  input wire logic sfr_hit_in,
  input wire logic [15:0] psv_rdata_in,
  output logic [23:0] pc_out,
  output data_space_pkg::pc_zone_t pc_zone_out,
  output logic [23:0] instr_out,
  output data_space_pkg::rd_port_t x_port_out,
  output data_space_pkg::rd_port_t y_port_out,
  output data_space_pkg::wr_port_t wr_port_out,
  output logic [15:0] x_data_out,
  output logic x_data_valid_out,
  output logic [15:0] y_data_out,
  output logic y_data_valid_out,
  output logic [15:0] x_next_ptr_out,
  output logic [15:0] y_next_ptr_out,
  output logic addr_err_out,
  output logic addr_err_is_write_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] eff_addr(input logic [15:0] a, input logic near_field);
    eff_addr = near_field ? (a & data_space_pkg::NEAR_MASK) : a;
  endfunction

  function automatic data_space_pkg::src_t decode(input logic [15:0] ea);
    if (ea[data_space_pkg::PSV_BIT]) begin
      decode = data_space_pkg::SRC_PSV;
    end else if (ea < data_space_pkg::SFR_LIMIT) begin
      decode = data_space_pkg::SRC_SFR;
    end else if (ea < RAM_LIMIT) begin
      decode = data_space_pkg::SRC_RAM;
    end else begin
      decode = data_space_pkg::SRC_ZERO;
    end
  endfunction

  function automatic logic [15:0] post_mod(input logic [15:0] a, input logic is_byte, input logic men,
                                           input data_space_pkg::mod_cfg_t cfg);
    logic [15:0] n;
    n = a + (is_byte ? data_space_pkg::BYTE_STEP : data_space_pkg::WORD_STEP);
    if (men && n > cfg.end_addr) begin
      n = cfg.start;
    end
    post_mod = n;
  endfunction

  function automatic logic [15:0] shape(input logic [15:0] w, input data_space_pkg::rd_stage_t s,
                                        input logic [15:0] old);
    logic [7:0] b;
    b = s.hi_byte ? w[15:8] : w[7:0];
    case (s.ext)
      data_space_pkg::EXT_SIGN: shape = {{8{b[7]}}, b};
      data_space_pkg::EXT_ZERO: shape = {8'h00, b};
      data_space_pkg::EXT_LOAD_LOW: shape = {old[15:8], b};
      default: shape = s.is_byte ? {8'h00, b} : w;
    endcase
  endfunction

  function automatic data_space_pkg::pc_zone_t zone_of(input logic [23:0] p);
    if (p >= data_space_pkg::PRI_IVT_LO && p <= data_space_pkg::PRI_IVT_HI) begin
      zone_of = data_space_pkg::ZONE_PRI_IVT;
    end else if (p >= data_space_pkg::ALT_IVT_LO && p <= data_space_pkg::ALT_IVT_HI) begin
      zone_of = data_space_pkg::ZONE_ALT_IVT;
    end else if (p < data_space_pkg::PRI_IVT_LO) begin
      zone_of = data_space_pkg::ZONE_RESET;
    end else begin
      zone_of = data_space_pkg::ZONE_USER;
    end
  endfunction

  // Reverses the low word-index bits; only the write path uses it
  function automatic logic [15:0] bit_reverse(input logic [15:0] a);
    logic [15:0] r;
    r = a;
    for (int i = 0; i < data_space_pkg::BITREV_BITS; i++) begin
      r[1 + i] = a[data_space_pkg::BITREV_BITS - i];
    end
    bit_reverse = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  data_space_pkg::core_state_t st;
  data_space_pkg::core_state_t next_st;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] w_ea;
  data_space_pkg::src_t x_src;
  data_space_pkg::src_t w_src;
  logic y_in_space;
  logic x_mis;
  logic y_mis;
  logic w_mis;
  logic [15:0] x_word;

  assign x_ea = eff_addr(x_rd_in.addr, x_rd_in.near_field); // RQ5 RQ17 RQ18
  assign y_ea = eff_addr(y_rd_in.addr, y_rd_in.near_field);
  assign w_ea = wr_in.bitrev ? bit_reverse(eff_addr(wr_in.addr, wr_in.near_field))
                             : eff_addr(wr_in.addr, wr_in.near_field); // RQ22
  assign x_src = decode(x_ea); // RQ6 RQ16
  assign w_src = decode(w_ea);
  // Boundary is fixed at build time so software cannot move it mid-filter
  assign y_in_space = (y_ea >= XY_BOUNDARY) && (y_ea < RAM_LIMIT) && !y_ea[data_space_pkg::PSV_BIT]; // RQ23
  assign x_mis = x_rd_in.valid && !x_rd_in.is_byte && x_ea[0]; // RQ12
  assign y_mis = y_rd_in.valid && !y_rd_in.is_byte && y_ea[0];
  assign w_mis = wr_in.valid && !wr_in.is_byte && w_ea[0];

  always_comb begin
    case (st.x_stage.src)
      data_space_pkg::SRC_RAM: x_word = x_ram_rdata_in;
      data_space_pkg::SRC_SFR: x_word = sfr_hit_in ? sfr_rdata_in : 16'h0000; // RQ16
      data_space_pkg::SRC_PSV: x_word = psv_rdata_in;
      default: x_word = 16'h0000; // RQ7
    endcase
  end

  always_comb begin
    next_st = st;
    case (pc_cmd_in)
      data_space_pkg::PC_FWD: next_st.pc = st.pc + data_space_pkg::PC_STEP; // RQ2
      data_space_pkg::PC_BACK: next_st.pc = st.pc - data_space_pkg::PC_STEP; // RQ2
      data_space_pkg::PC_LOAD: next_st.pc = {pc_target_in[23:1], 1'b0}; // RQ2
      default: next_st.pc = st.pc;
    endcase
    next_st.zone = zone_of(next_st.pc); // RQ3 RQ4
    next_st.instr = {prog_upper_in[7:0], prog_lower_in}; // RQ1

    // Misaligned reads still fetch the containing word so the instruction completes
    next_st.x_port.ram_en = x_rd_in.valid && x_src == data_space_pkg::SRC_RAM; // RQ20
    next_st.x_port.sfr_en = x_rd_in.valid && x_src == data_space_pkg::SRC_SFR;
    next_st.x_port.psv_en = x_rd_in.valid && x_src == data_space_pkg::SRC_PSV; // RQ6
    next_st.x_port.word_addr = x_ea[15:1]; // RQ10 RQ13
    next_st.x_stage = '{valid: x_rd_in.valid, hi_byte: x_rd_in.is_byte && x_ea[0], is_byte: x_rd_in.is_byte,
                        ext: x_rd_in.ext, src: x_src}; // RQ8 RQ10
    if (x_rd_in.valid && x_rd_in.post_inc) begin
      next_st.x_next = post_mod(x_rd_in.addr, x_rd_in.is_byte, x_rd_in.modulo_en, x_mod_in); // RQ9 RQ22
    end

    // Y side serves only the second operand of multiply-accumulate prefetch
    next_st.y_port.ram_en = y_rd_in.valid && y_in_space; // RQ19 RQ21
    next_st.y_port.sfr_en = 1'b0;
    next_st.y_port.psv_en = 1'b0;
    next_st.y_port.word_addr = y_ea[15:1];
    next_st.y_stage = '{valid: y_rd_in.valid, hi_byte: y_rd_in.is_byte && y_ea[0], is_byte: y_rd_in.is_byte,
                        ext: y_rd_in.ext, src: y_in_space ? data_space_pkg::SRC_RAM : data_space_pkg::SRC_ZERO};
    if (y_rd_in.valid && y_rd_in.post_inc) begin
      next_st.y_next = post_mod(y_rd_in.addr, y_rd_in.is_byte, y_rd_in.modulo_en, y_mod_in); // RQ9 RQ22
    end

    // One write path covers X and Y; writes beyond implemented space are dropped
    next_st.wr.en = wr_in.valid && !w_mis
                    && (w_src == data_space_pkg::SRC_RAM || w_src == data_space_pkg::SRC_SFR); // RQ13 RQ21
    next_st.wr.be = wr_in.is_byte ? (w_ea[0] ? 2'b10 : 2'b01) : 2'b11; // RQ11
    next_st.wr.word_addr = w_ea[15:1];
    next_st.wr.data = wr_in.is_byte ? {2{wr_in.data[7:0]}} : wr_in.data; // RQ8

    next_st.err = x_mis || y_mis || w_mis; // RQ12 RQ24
    next_st.err_wr = w_mis; // RQ24

    next_st.x_valid = st.x_stage.valid;
    next_st.x_data = shape(x_word, st.x_stage, x_wreg_old_in); // RQ10 RQ14 RQ15
    next_st.y_valid = st.y_stage.valid;
    next_st.y_data = shape(st.y_stage.src == data_space_pkg::SRC_RAM ? y_ram_rdata_in : 16'h0000,
                           st.y_stage, 16'h0000); // RQ7
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
      st.pc <= data_space_pkg::PC_RESET; // RQ3
      st.zone <= data_space_pkg::ZONE_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pc_out = st.pc;
  assign pc_zone_out = st.zone;
  assign instr_out = st.instr;
  assign x_port_out = st.x_port;
  assign y_port_out = st.y_port;
  assign wr_port_out = st.wr;
  assign x_data_out = st.x_data;
  assign x_data_valid_out = st.x_valid;
  assign y_data_out = st.y_data;
  assign y_data_valid_out = st.y_valid;
  assign x_next_ptr_out = st.x_next;
  assign y_next_ptr_out = st.y_next;
  assign addr_err_out = st.err;
  assign addr_err_is_write_out = st.err_wr;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_pc_step_fwd: assert property (pc_cmd_in == data_space_pkg::PC_FWD |=> pc_out == $past(pc_out) + 24'h000002) // RQ2
    else $error("pc forward step wrong");
  a_pc_even: assert property (pc_out[0] == 1'b0) // RQ2
    else $error("pc not word aligned");
  a_instr_pack: assert property (1'b1 |=> instr_out == {$past(prog_upper_in[7:0]), $past(prog_lower_in)}) // RQ1
    else $error("instruction packing wrong");
  a_zone_tables: assert property ((pc_out >= 24'h000004 && pc_out <= 24'h0000ff) |-> // RQ4
                                  pc_zone_out == data_space_pkg::ZONE_PRI_IVT)
    else $error("primary table zone wrong");
  a_read_misalign: assert property (x_mis && !w_mis |=> addr_err_out && !addr_err_is_write_out) // RQ12
    else $error("misaligned read not trapped");
  a_write_suppress: assert property (w_mis |=> !wr_port_out.en && addr_err_out && addr_err_is_write_out) // RQ13
    else $error("misaligned write not suppressed");
  a_err_single: assert property (!x_mis && !y_mis && !w_mis |=> !addr_err_out) // RQ24
    else $error("address error not a pulse");
  a_byte_lane: assert property (wr_in.valid && wr_in.is_byte && w_src == data_space_pkg::SRC_RAM |=> // RQ11
                                wr_port_out.en && wr_port_out.be == ($past(w_ea[0]) ? 2'b10 : 2'b01))
    else $error("byte strobe wrong");
  a_psv_route: assert property (x_rd_in.valid && x_ea[15] |=> x_port_out.psv_en && !x_port_out.ram_en) // RQ6
    else $error("upper half not routed to window");
  a_post_inc: assert property (x_rd_in.valid && x_rd_in.post_inc && !x_rd_in.modulo_en |=> // RQ9
                               x_next_ptr_out == $past(x_rd_in.addr) +
                               ($past(x_rd_in.is_byte) ? 16'h0001 : 16'h0002))
    else $error("post increment step wrong");
  a_sfr_zero: assert property (x_rd_in.valid && x_ea < 16'h0800 && x_rd_in.ext == data_space_pkg::EXT_NONE // RQ16
                               ##1 !sfr_hit_in |=> x_data_valid_out && x_data_out == 16'h0000)
    else $error("unused special register not zero");
  a_y_outside: assert property (y_rd_in.valid && !y_in_space && y_rd_in.ext != data_space_pkg::EXT_LOAD_LOW // RQ21
                                |-> ##2 y_data_valid_out && y_data_out == 16'h0000)
    else $error("y read outside y space not zero");
  a_pc_back: assert property (pc_cmd_in == data_space_pkg::PC_BACK |=> pc_out == $past(pc_out) - 24'h000002) // RQ2
    else $error("pc backward step wrong");
  a_pc_load: assert property (pc_cmd_in == data_space_pkg::PC_LOAD |=> // RQ2
                              pc_out == {$past(pc_target_in[23:1]), 1'b0})
    else $error("pc load not word aligned");
  a_zone_alt: assert property ((pc_out >= 24'h000100 && pc_out <= 24'h0001ff) |-> // RQ4
                               pc_zone_out == data_space_pkg::ZONE_ALT_IVT)
    else $error("alternate table zone wrong");
  a_zone_reset: assert property (pc_out < 24'h000004 |-> pc_zone_out == data_space_pkg::ZONE_RESET) // RQ3
    else $error("reset vector zone wrong");
  // A load-low merge keeps the old high byte, so it is left out of the zero check
  a_unimpl_zero: assert property (x_rd_in.valid && x_src == data_space_pkg::SRC_ZERO && // RQ7
                                  x_rd_in.ext != data_space_pkg::EXT_LOAD_LOW |->
                                  ##2 x_data_valid_out && x_data_out == 16'h0000)
    else $error("unimplemented read not zero");
  a_byte_copy: assert property (wr_in.valid && wr_in.is_byte |=> // RQ8
                                wr_port_out.data == {2{$past(wr_in.data[7:0])}})
    else $error("byte write data not on both lanes");
  a_y_space: assert property (y_rd_in.valid && y_ea >= XY_BOUNDARY && y_ea < RAM_LIMIT |=> y_port_out.ram_en) // RQ23
    else $error("y read inside y space not issued");
  a_load_low: assert property (x_rd_in.valid && x_rd_in.ext == data_space_pkg::EXT_LOAD_LOW |=> // RQ14
                               ##1 x_data_out[15:8] == $past(x_wreg_old_in[15:8]))
    else $error("byte load changed high byte");
  a_sign_ext: assert property (x_rd_in.valid && x_rd_in.ext == data_space_pkg::EXT_SIGN |=> // RQ15
                               ##1 x_data_out[15:8] == {8{x_data_out[7]}})
    else $error("sign extension wrong");
  a_mod_wrap: assert property (x_rd_in.valid && x_rd_in.post_inc && x_rd_in.modulo_en && // RQ22
                               x_rd_in.addr + (x_rd_in.is_byte ? 16'h0001 : 16'h0002) > x_mod_in.end_addr |=>
                               x_next_ptr_out == $past(x_mod_in.start))
    else $error("modulo wrap wrong");

  c_dual_read: cover property (x_rd_in.valid && y_rd_in.valid ##2 x_data_valid_out && y_data_valid_out);
  c_odd_byte_read: cover property (x_rd_in.valid && x_rd_in.is_byte && x_ea[0] ##2 x_data_valid_out);
  c_mis_write: cover property (w_mis ##1 addr_err_is_write_out);
  c_pc_load: cover property (pc_cmd_in == data_space_pkg::PC_LOAD ##1 pc_zone_out == data_space_pkg::ZONE_USER);
  c_mod_wrap: cover property (x_rd_in.valid && x_rd_in.modulo_en ##1 x_next_ptr_out == x_mod_in.start);

endmodule

/* verification/ram_model.sv */
`timescale 1ns/1ps
module ram_model (
  input wire logic core_clk_in,
  input wire data_space_pkg::rd_port_t x_port_in,
  input wire data_space_pkg::rd_port_t y_port_in,
  input wire data_space_pkg::wr_port_t wr_port_in,
  output logic [15:0] x_rdata_out,
  output logic [15:0] y_rdata_out,
  output logic [15:0] sfr_rdata_out,
  output logic sfr_hit_out,
  output logic [15:0] psv_rdata_out
);
  logic [15:0] mem [0:32767];
  logic [15:0] junk = 16'h5a5a;
  // Every word starts as its own index so any read has a known value
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 16'(i);
    end
  end
  // Unselected buses show a moving pattern so stale data cannot pass
  always @(posedge core_clk_in) begin
    junk <= ~junk + 16'h0001;
    if (wr_port_in.en && wr_port_in.be[0]) begin
      mem[wr_port_in.word_addr][7:0] <= wr_port_in.data[7:0];
    end
    if (wr_port_in.en && wr_port_in.be[1]) begin
      mem[wr_port_in.word_addr][15:8] <= wr_port_in.data[15:8];
    end
  end
  assign x_rdata_out = x_port_in.ram_en ? mem[x_port_in.word_addr] : junk;
  assign y_rdata_out = y_port_in.ram_en ? mem[y_port_in.word_addr] : junk;
  // Odd word slots of the register area are left unused
  assign sfr_hit_out = x_port_in.sfr_en & ~x_port_in.word_addr[0];
  assign sfr_rdata_out = sfr_hit_out ? {1'b1, x_port_in.word_addr} : junk;
  assign psv_rdata_out = x_port_in.psv_en ? {1'b0, ~x_port_in.word_addr} : junk;
endmodule

/* verification/data_space_access_unit_test.sv */
`timescale 1ns/1ps
module data_space_access_unit_test;
  logic clk = 1'b0, rst_n = 1'b0, err, err_w, xv, yv, sfr_hit;
  data_space_pkg::pc_cmd_t pc_cmd = data_space_pkg::PC_HOLD;
  logic [23:0] pc_tgt = 24'h000000, pc, instr;
  logic [15:0] pl = 16'h0000, pu = 16'h0000, wold = 16'h5a77, xd, yd, xn, yn, xr, yr, sr, pr, np;
  data_space_pkg::rd_req_t x_rd = '0, y_rd = '0;
  data_space_pkg::wr_req_t wr = '0;
  data_space_pkg::mod_cfg_t x_mod = '0, y_mod = '0;
  data_space_pkg::pc_zone_t zone;
  data_space_pkg::rd_port_t xp, yp, p1;
  data_space_pkg::wr_port_t wp;
  int n_fail = 0, checked = 0;
  data_space_access_unit #(.RAM_LIMIT(16'h7800), .XY_BOUNDARY(16'h4800)) i_dut (.core_clk_in(clk),
    .reset_n_in(rst_n), .pc_cmd_in(pc_cmd), .pc_target_in(pc_tgt), .prog_lower_in(pl), .prog_upper_in(pu),
    .x_rd_in(x_rd), .y_rd_in(y_rd), .wr_in(wr), .x_mod_in(x_mod), .y_mod_in(y_mod), .x_wreg_old_in(wold),
    .x_ram_rdata_in(xr), .y_ram_rdata_in(yr), .sfr_rdata_in(sr), .sfr_hit_in(sfr_hit), .psv_rdata_in(pr),
    .pc_out(pc), .pc_zone_out(zone), .instr_out(instr), .x_port_out(xp), .y_port_out(yp), .wr_port_out(wp),
    .x_data_out(xd), .x_data_valid_out(xv), .y_data_out(yd), .y_data_valid_out(yv), .x_next_ptr_out(xn),
    .y_next_ptr_out(yn), .addr_err_out(err), .addr_err_is_write_out(err_w));
  ram_model i_ram (.core_clk_in(clk), .x_port_in(xp), .y_port_in(yp), .wr_port_in(wp), .x_rdata_out(xr),
    .y_rdata_out(yr), .sfr_rdata_out(sr), .sfr_hit_out(sfr_hit), .psv_rdata_out(pr));
  initial begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic data_space_pkg::rd_req_t mk(input logic [15:0] a, input logic b,
                                                 input data_space_pkg::ext_op_t e, input logic pi);
    mk = '{valid: 1'b1, is_byte: b, near_field: 1'b0, post_inc: pi, modulo_en: 1'b0, ext: e, addr: a};
  endfunction
  // One X read: request, check the error at cycle 1, data at cycle 2
  task rd(input data_space_pkg::rd_req_t q, input logic [15:0] exp, input logic exp_err);
    @(negedge clk) x_rd = q;
    @(negedge clk) x_rd = '0;
    chk({err, err_w}, {exp_err, 1'b0});
    p1 = xp;
    np = xn;
    @(negedge clk);
    chk(err, 1'b0);
    chk(xv, 1'b1);
    chk(xd, exp);
  endtask
  task wrt(input logic [15:0] a, input logic [15:0] d, input logic b, input logic br, input logic en,
           input logic [1:0] be, input logic [14:0] wa, input logic e);
    @(negedge clk) wr = '{valid: 1'b1, is_byte: b, near_field: 1'b0, bitrev: br, addr: a, data: d};
    @(negedge clk) wr = '0;
    chk(wp.en, en);
    chk({err, err_w}, {e, e});
    if (en) begin
      chk({wp.be, wp.word_addr}, {be, wa});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_pc;
    logic [23:0] tg [5] = '{24'h0000ff, 24'h000101, 24'h0001fe, 24'h000200, 24'h000003};
    data_space_pkg::pc_zone_t zn [5] = '{data_space_pkg::ZONE_PRI_IVT, data_space_pkg::ZONE_ALT_IVT,
      data_space_pkg::ZONE_ALT_IVT, data_space_pkg::ZONE_USER, data_space_pkg::ZONE_RESET};
    chk({pc, zone}, {24'h000000, data_space_pkg::ZONE_RESET});
    @(negedge clk) pc_cmd = data_space_pkg::PC_FWD;
    @(negedge clk) chk(pc, 24'h000002);
    @(negedge clk) chk({pc, zone}, {24'h000004, data_space_pkg::ZONE_PRI_IVT});
    for (int i = 0; i < 5; i++) begin
      @(negedge clk) pc_cmd = data_space_pkg::PC_LOAD;
      pc_tgt = tg[i];
      @(negedge clk) chk({pc, zone}, {tg[i][23:1], 1'b0, zn[i]});
    end
    pc_cmd = data_space_pkg::PC_BACK;
    pl = 16'hbeef;
    pu = 16'h77c3;
    @(negedge clk) pc_cmd = data_space_pkg::PC_HOLD;
    chk({pc, instr}, {24'h000000, 24'hc3beef});
    $display("test pc done");
  endtask
  task t_lanes;
    wrt(16'h1000, 16'h1234, 1'b0, 1'b0, 1'b1, 2'h3, 15'h0800, 1'b0);
    wrt(16'h1001, 16'h00ab, 1'b1, 1'b0, 1'b1, 2'h2, 15'h0800, 1'b0);
    chk(wp.data, 16'habab);
    rd(mk(16'h1000, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'hab34, 1'b0);
    rd(mk(16'h1001, 1'b1, data_space_pkg::EXT_NONE, 1'b0), 16'h00ab, 1'b0);
    rd(mk(16'h1001, 1'b1, data_space_pkg::EXT_SIGN, 1'b0), 16'hffab, 1'b0);
    rd(mk(16'h1000, 1'b1, data_space_pkg::EXT_ZERO, 1'b0), 16'h0034, 1'b0);
    rd(mk(16'h1000, 1'b1, data_space_pkg::EXT_LOAD_LOW, 1'b0), 16'h5a34, 1'b0);
    wrt(16'h1002, 16'h4321, 1'b0, 1'b1, 1'b1, 2'h3, 15'h0880, 1'b0);
    $display("test lanes done");
  endtask
  task t_misaligned;
    rd(mk(16'h1001, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'hab34, 1'b1);
    wrt(16'h1003, 16'hffff, 1'b0, 1'b0, 1'b0, 2'h0, 15'h0000, 1'b1);
    rd(mk(16'h1002, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h0801, 1'b0);
    $display("test misaligned done");
  endtask
  task t_regions;
    data_space_pkg::rd_req_t q;
    rd(mk(16'h7900, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h0000, 1'b0);
    chk(p1.ram_en, 1'b0);
    wrt(16'h7900, 16'h1111, 1'b0, 1'b0, 1'b0, 2'h0, 15'h0000, 1'b0);
    rd(mk(16'h8004, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h3ffd, 1'b0);
    chk(p1.psv_en, 1'b1);
    rd(mk(16'h0004, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h8002, 1'b0);
    rd(mk(16'h0006, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h0000, 1'b0);
    q = mk(16'h3004, 1'b0, data_space_pkg::EXT_NONE, 1'b0);
    q.near_field = 1'b1;
    rd(q, 16'h0802, 1'b0);
    rd(mk(16'h3004, 1'b0, data_space_pkg::EXT_NONE, 1'b0), 16'h1802, 1'b0);
    wrt(16'h8004, 16'h2222, 1'b0, 1'b0, 1'b0, 2'h0, 15'h0000, 1'b0);
    wrt(16'h0004, 16'h3333, 1'b0, 1'b0, 1'b1, 2'h3, 15'h0002, 1'b0);
    $display("test regions done");
  endtask
  task t_postinc;
    data_space_pkg::rd_req_t q;
    rd(mk(16'h2000, 1'b1, data_space_pkg::EXT_NONE, 1'b1), 16'h0000, 1'b0);
    chk(np, 16'h2001);
    rd(mk(16'h2002, 1'b0, data_space_pkg::EXT_NONE, 1'b1), 16'h1001, 1'b0);
    chk(np, 16'h2004);
    x_mod = '{start: 16'h2000, end_addr: 16'h2003};
    q = mk(16'h2002, 1'b0, data_space_pkg::EXT_NONE, 1'b1);
    q.modulo_en = 1'b1;
    rd(q, 16'h1001, 1'b0);
    chk(np, 16'h2000);
    y_mod = '{start: 16'h5000, end_addr: 16'h5003};
    q.addr = 16'h5002;
    @(negedge clk) y_rd = q;
    @(negedge clk) y_rd = '0;
    chk(yn, 16'h5000);
    @(negedge clk) chk({yv, yd}, {1'b1, 16'h2801});
    $display("test postinc done");
  endtask
  task t_dual;
    @(negedge clk) x_rd = mk(16'h1000, 1'b0, data_space_pkg::EXT_NONE, 1'b0);
    y_rd = mk(16'h5000, 1'b0, data_space_pkg::EXT_NONE, 1'b0);
    @(negedge clk) x_rd = '0;
    y_rd = mk(16'h1000, 1'b0, data_space_pkg::EXT_NONE, 1'b0);
    chk({xp.ram_en, yp.ram_en, yp.sfr_en}, 3'h6);
    @(negedge clk) y_rd = '0;
    chk({xv, yv, xd, yd}, {2'h3, 16'hab34, 16'h2800});
    chk(yp.ram_en, 1'b0);
    @(negedge clk) chk(yd, 16'h0000);
    $display("test dual done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_pc();
    t_lanes();
    t_misaligned();
    t_regions();
    t_postinc();
    t_dual();
    finish_test();
  end
endmodule
